// file: hw/iex_top.sv
// Interrupt expander for one core, with Avalon-MM register slave
`timescale 1ns/100ps
module iex_top (
  input  logic                                   sys_clk,
  input  logic                                   rst_b,
  input  logic [iex_pkg::IEX_SOURCES-1:0]        periph_irq,
  input  logic                                   timer1_irq,
  input  logic                                   timer2_irq,
  input  logic [iex_pkg::IEX_ADDR_W-1:0]         avs_address,
  input  logic                                   avs_read,
  input  logic                                   avs_write,
  input  logic [iex_pkg::IEX_DATA_W-1:0]         avs_writedata,
  output logic [iex_pkg::IEX_DATA_W-1:0]         avs_readdata,
  output logic                                   avs_waitrequest,
  input  logic                                   core_take,
  output logic                                   cpu_irq,
  output iex_pkg::iex_vec_s                      vec_out,
  output logic                                   boot_fetch,
  output logic [iex_pkg::IEX_PC_W-1:0]           boot_addr,
  output logic                                   irq
);
  import iex_pkg::*;

  // Lowest set bit wins; msb of result says anything was found
  function automatic logic [4:0] first_set16(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // Group register decode: {hit, enable_select, group index}
  function automatic logic [5:0] group_decode(input logic [11:0] a);
    logic [5:0] r;
    r = 6'h00;
    if (a[11:8] == IEX_GROUP_PAGE && !a[7] && a[6:3] < 4'(IEX_GROUPS)) begin
      r = {1'b1, a[2], a[6:3]};
    end
    return r;
  endfunction

  logic                   bus_done_reg;
  logic                   wr_go;
  logic [31:0]            rd_next;
  logic [31:0]            rd_reg;
  logic [5:0]             gdec;
  logic                   exp_en_reg;
  logic                   gmask_reg;
  logic [IEX_SOURCES-1:0] irq_prev_reg;
  logic [IEX_SOURCES-1:0] irq_rise;
  logic                   t1_prev_reg;
  logic                   t2_prev_reg;
  logic [15:0]            gflag_reg [IEX_GROUPS];
  logic [15:0]            gen_reg [IEX_GROUPS];
  logic [15:0]            gclr [IEX_GROUPS];
  logic [IEX_SOURCES-1:0] gflag_flat;
  logic [IEX_GROUPS-1:0]  ack_reg;
  logic [IEX_GROUPS-1:0]  group_fwd;
  logic [IEX_LINES-1:0]   cflag_reg;
  logic [IEX_LINES-1:0]   cen_reg;
  logic [IEX_LINES-1:0]   cpend;
  logic [IEX_LINES-1:0]   cset;
  logic [IEX_LINES-1:0]   cclr;
  logic [4:0]             line_pick;
  iex_state_e             state_reg;
  logic [3:0]             sel_line_reg;
  logic                   take_go;
  logic                   refuse;
  logic                   sel_grouped;
  logic [3:0]             sel_gidx;
  logic [4:0]             bit_pick;
  logic                   fetch_found;
  logic [7:0]             vec_idx;
  logic [31:0]            vram [IEX_VEC_DEPTH];
  iex_vec_s               vec_reg;
  logic [7:0]             lastvec_reg;
  logic [IEX_EVT_W-1:0]   evt_reg;
  logic [IEX_EVT_W-1:0]   emask_reg;
  logic [IEX_EVT_W-1:0]   evt_set;
  logic                   boot_pend_reg;
  logic [IEX_PC_W-1:0]    boot_addr_reg;

  // Every access takes two cycles, so read data always comes from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_done_reg;
  assign wr_go           = avs_write & bus_done_reg;
  assign gdec            = group_decode(avs_address);
  assign avs_readdata    = rd_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_done_reg <= 1'b0;
      rd_reg       <= 32'h0;
    end else begin
      bus_done_reg <= (avs_read | avs_write) & ~bus_done_reg;
      if (avs_read && !bus_done_reg) begin
        rd_reg <= rd_next;
      end
    end
  end

  always_comb begin
    rd_next = 32'h0;
    if (avs_address[11:10] == IEX_VRAM_PAGE) begin
      rd_next = vram[avs_address[9:2]];
    end else if (gdec[5]) begin
      rd_next = gdec[4] ? {16'h0, gen_reg[gdec[3:0]]} : {16'h0, gflag_reg[gdec[3:0]]};
    end else begin
      case (avs_address)
        IEX_CTRL_OFS:    rd_next = {30'h0, gmask_reg, exp_en_reg};
        IEX_ACK_OFS:     rd_next = {20'h0, ack_reg};
        IEX_CFLAG_OFS:   rd_next = {18'h0, cflag_reg};
        IEX_CEN_OFS:     rd_next = {18'h0, cen_reg};
        IEX_EVT_OFS:     rd_next = {29'h0, evt_reg};
        IEX_EMASK_OFS:   rd_next = {29'h0, emask_reg};
        IEX_LASTVEC_OFS: rd_next = {24'h0, lastvec_reg};
        default:         rd_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_go && avs_address[11:10] == IEX_VRAM_PAGE) begin
      vram[avs_address[9:2]] <= avs_writedata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_en_reg <= IEX_EN_RST;
      gmask_reg  <= IEX_GMASK_RST;
    end else begin
      if (wr_go && avs_address == IEX_CTRL_OFS) begin
        exp_en_reg <= avs_writedata[IEX_CTRL_EN_BIT];
        gmask_reg  <= avs_writedata[IEX_CTRL_GMASK_BIT];
      end
      // The core masks further interrupts while it enters a routine
      if (take_go) begin
        gmask_reg <= 1'b1;
      end
    end
  end

  // shared sources wired to every instance
  assign irq_rise = periph_irq & ~irq_prev_reg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_prev_reg <= '0;
      t1_prev_reg  <= 1'b0;
      t2_prev_reg  <= 1'b0;
    end else begin
      irq_prev_reg <= periph_irq;
      t1_prev_reg  <= timer1_irq;
      t2_prev_reg  <= timer2_irq;
    end
  end

  always_comb begin
    for (int g = 0; g < IEX_GROUPS; g++) begin
      gclr[g] = 16'h0;
      if (wr_go && gdec[5] && !gdec[4] && gdec[3:0] == 4'(g)) begin
        gclr[g] = avs_writedata[15:0];
      end
      if (state_reg == IEX_FETCH && sel_grouped && fetch_found && sel_gidx == 4'(g)) begin
        gclr[g][bit_pick[3:0]] = 1'b1;
      end
    end
  end

  // rising edge sets flag, set beats clear
  // merged events land on one flag bit
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < IEX_GROUPS; g++) begin
        gflag_reg[g] <= 16'h0;
      end
    end else begin
      for (int g = 0; g < IEX_GROUPS; g++) begin
        gflag_reg[g] <= (gflag_reg[g] & ~gclr[g]) | irq_rise[g*IEX_GROUP_W +: IEX_GROUP_W];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int g = 0; g < IEX_GROUPS; g++) begin
        gen_reg[g] <= 16'h0;
      end
    end else if (wr_go && gdec[5] && gdec[4]) begin
      gen_reg[gdec[3:0]] <= avs_writedata[15:0];
    end
  end

  always_comb begin
    for (int g = 0; g < IEX_GROUPS; g++) begin
      gflag_flat[g*IEX_GROUP_W +: IEX_GROUP_W] = gflag_reg[g];
      group_fwd[g] = exp_en_reg & ~ack_reg[g] & (|(gflag_reg[g] & gen_reg[g]));
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= '0;
    end else begin
      if (wr_go && avs_address == IEX_ACK_OFS) begin
        ack_reg <= (ack_reg & ~avs_writedata[IEX_GROUPS-1:0]) | group_fwd;
      end else begin
        ack_reg <= ack_reg | group_fwd;
      end
    end
  end

  // grouped lines plus two timer lines
  // one grouped line per sixteen sources
  assign cset = {timer2_irq & ~t2_prev_reg, timer1_irq & ~t1_prev_reg, group_fwd};

  always_comb begin
    cclr = '0;
    if (wr_go && avs_address == IEX_CFLAG_OFS) begin
      cclr = avs_writedata[IEX_LINES-1:0];
    end
    if (take_go) begin
      cclr[line_pick[3:0]] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cflag_reg <= '0;
      cen_reg   <= '0;
    end else begin
      cflag_reg <= (cflag_reg & ~cclr) | cset;
      if (wr_go && avs_address == IEX_CEN_OFS) begin
        cen_reg <= avs_writedata[IEX_LINES-1:0];
      end
    end
  end

  assign cpend   = cflag_reg & cen_reg;
  assign cpu_irq = ~gmask_reg & (|cpend);

  assign line_pick = first_set16({2'b00, cpend});
  assign take_go   = (state_reg == IEX_IDLE) & core_take & cpu_irq & exp_en_reg;
  assign refuse    = (state_reg == IEX_IDLE) & core_take & ~exp_en_reg;

  assign sel_grouped = sel_line_reg < IEX_TIMER1_LINE;
  assign sel_gidx    = sel_grouped ? sel_line_reg : 4'h0;
  assign bit_pick    = first_set16(gflag_reg[sel_gidx] & gen_reg[sel_gidx]);
  assign fetch_found = sel_grouped ? bit_pick[4] : 1'b1;

  always_comb begin
    if (sel_grouped) begin
      vec_idx = {sel_line_reg, bit_pick[3:0]};
    end else if (sel_line_reg == IEX_TIMER1_LINE) begin
      vec_idx = IEX_TIMER1_VEC;
    end else begin
      vec_idx = IEX_TIMER2_VEC;
    end
  end

  // take, fetch from vector RAM, deliver
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= IEX_IDLE;
      sel_line_reg <= 4'h0;
      vec_reg      <= '0;
      lastvec_reg  <= 8'h0;
    end else begin
      case (state_reg)
        IEX_IDLE: begin
          vec_reg.valid <= 1'b0;
          if (take_go) begin
            sel_line_reg <= line_pick[3:0];
            state_reg    <= IEX_FETCH;
          end
        end
        IEX_FETCH: begin
          // Flags may be cleared by software after forwarding: then nothing is delivered
          vec_reg.valid <= fetch_found;
          vec_reg.index <= vec_idx;
          vec_reg.addr  <= vram[vec_idx];
          if (fetch_found) begin
            lastvec_reg <= vec_idx;
          end
          state_reg <= IEX_DONE;
        end
        IEX_DONE: begin
          vec_reg.valid <= 1'b0;
          state_reg     <= IEX_IDLE;
        end
        default: begin
          vec_reg.valid <= 1'b0;
          state_reg     <= IEX_IDLE;
        end
      endcase
    end
  end

  assign vec_out = vec_reg;

  always_comb begin
    evt_set                   = '0;
    evt_set[IEX_EVT_DELIVER]  = (state_reg == IEX_FETCH) & fetch_found;
    evt_set[IEX_EVT_REFUSE]   = refuse;
    evt_set[IEX_EVT_SPURIOUS] = (state_reg == IEX_FETCH) & ~fetch_found;
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_reg   <= '0;
      emask_reg <= '0;
    end else begin
      if (wr_go && avs_address == IEX_EVT_OFS) begin
        evt_reg <= (evt_reg & ~avs_writedata[IEX_EVT_W-1:0]) | evt_set;
      end else begin
        evt_reg <= evt_reg | evt_set;
      end
      if (wr_go && avs_address == IEX_EMASK_OFS) begin
        emask_reg <= avs_writedata[IEX_EVT_W-1:0];
      end
    end
  end

  assign irq = |(evt_reg & emask_reg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_pend_reg <= 1'b1;
      boot_addr_reg <= IEX_RESET_VECTOR;
    end else begin
      boot_pend_reg <= 1'b0;
      boot_addr_reg <= IEX_RESET_VECTOR;
    end
  end

  assign boot_fetch = boot_pend_reg;
  assign boot_addr  = boot_addr_reg;

  // all state is local to this instance; one instance per core

  a_boot_state_clean: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    boot_fetch |-> (!exp_en_reg && gmask_reg && !cpu_irq && cflag_reg == '0)
  ) else $error("expander not quiet at boot");

  a_boot_vector_once: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    boot_fetch |-> (boot_addr == IEX_RESET_VECTOR) ##1 !boot_fetch
  ) else $error("reset vector not presented once");

  a_gmask_blocks_irq: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    gmask_reg |-> !cpu_irq
  ) else $error("request passed global mask");

  a_irq_needs_line: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    cpu_irq |-> ((cflag_reg & cen_reg) != '0)
  ) else $error("request without enabled line flag");

  // An acknowledged group must never raise its core line flag on the next edge
  a_ack_blocks_group: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> ((cflag_reg[IEX_GROUPS-1:0] & ~$past(cflag_reg[IEX_GROUPS-1:0]) & $past(ack_reg)) == '0)
  ) else $error("acknowledged group still forwarded");

  a_fwd_sets_ack: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (group_fwd != '0) |=> ((ack_reg & $past(group_fwd)) == $past(group_fwd))
  ) else $error("forwarding left acknowledge clear");

  a_edge_sets_flag: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    (irq_rise != '0) |=> ((gflag_flat & $past(irq_rise)) == $past(irq_rise))
  ) else $error("peripheral edge lost");

  a_take_lowest_line: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    take_go |=> (sel_line_reg == $past(line_pick[3:0])) && (($past(cpend) & ((14'h1 << sel_line_reg) - 14'h1)) == '0)
  ) else $error("wrong line chosen on take");

  a_take_delivers: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    take_go |-> ##2 (vec_out.valid || evt_reg[IEX_EVT_SPURIOUS])
  ) else $error("take produced no vector");

  a_refuse_disabled: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    refuse |=> (state_reg == IEX_IDLE && !vec_out.valid && evt_reg[IEX_EVT_REFUSE])
  ) else $error("vector taken while disabled");

endmodule // iex_top

// file: pkg/iex_pkg.sv
// Constants, types and register map of the interrupt expander
// Function
// - Fourteen core lines; lines 13 and 14 from timers, 1 to 12 grouped.
// - Up to sixteen peripheral signals per grouped line, 192 sources in all.
// - Every peripheral signal owns its own vector table entry and routine address.
// - One pending flag and one enable bit per peripheral signal.
// - Sixteen signals sharing a core line form a group; twelve groups.
// - Per group 16-bit flags, 16-bit enables, one acknowledge bit masking the group.
// - One flag bit and one enable bit per core interrupt line.
// - One global mask bit gates all maskable core lines.
// - Request reaches core only with group flag, group enable, line flag, line enable, unmasked; code keeps the line request after the group flag is cleared.
// - On take, vector fetched from vector RAM for lowest flagged and enabled source.
// - Lowest table position wins when several interrupts are pending.
// - Merged peripheral events share one signal; software reads peripheral status to tell.
// - Each core has its own independently configured expander instance.
// - Shared peripheral interrupts reach both cores' expanders regardless of owner.
// - After reset the expander is disabled and the global mask blocks interrupts.
// - On reset the fixed reset vector address is presented for the first fetch.
package iex_pkg;
  localparam int          IEX_GROUPS      = 12;
  localparam int          IEX_GROUP_W     = 16;
  localparam int          IEX_LINES       = 14;
  localparam int          IEX_SOURCES     = 192;
  localparam int          IEX_VEC_DEPTH   = 256;
  localparam int          IEX_ADDR_W      = 12;
  localparam int          IEX_DATA_W      = 32;
  localparam int          IEX_PC_W        = 22;
  localparam logic [3:0]  IEX_TIMER1_LINE = 4'hc;
  localparam logic [3:0]  IEX_TIMER2_LINE = 4'hd;
  localparam logic [7:0]  IEX_TIMER1_VEC  = 8'hc0;
  localparam logic [7:0]  IEX_TIMER2_VEC  = 8'hc1;
  localparam logic [21:0] IEX_RESET_VECTOR = 22'h3fffc0;
  // Register byte offsets
  localparam logic [11:0] IEX_CTRL_OFS    = 12'h000;
  localparam logic [11:0] IEX_ACK_OFS     = 12'h004;
  localparam logic [11:0] IEX_CFLAG_OFS   = 12'h008;
  localparam logic [11:0] IEX_CEN_OFS     = 12'h00c;
  localparam logic [11:0] IEX_EVT_OFS     = 12'h010;
  localparam logic [11:0] IEX_EMASK_OFS   = 12'h014;
  localparam logic [11:0] IEX_LASTVEC_OFS = 12'h018;
  localparam logic [3:0]  IEX_GROUP_PAGE  = 4'h1;
  localparam logic [1:0]  IEX_VRAM_PAGE   = 2'h1;
  // Field positions and reset values
  localparam int          IEX_CTRL_EN_BIT    = 0;
  localparam int          IEX_CTRL_GMASK_BIT = 1;
  localparam logic        IEX_EN_RST         = 1'b0;
  localparam logic        IEX_GMASK_RST      = 1'b1;
  localparam int          IEX_EVT_DELIVER    = 0;
  localparam int          IEX_EVT_REFUSE     = 1;
  localparam int          IEX_EVT_SPURIOUS   = 2;
  localparam int          IEX_EVT_W          = 3;

  typedef enum {IEX_IDLE, IEX_FETCH, IEX_DONE} iex_state_e;

  typedef struct packed {
    logic        valid;
    logic [7:0]  index;
    logic [31:0] addr;
  } iex_vec_s;
endpackage

// file: verif/iex_core_model.sv
// Behavioural model of the core that takes interrupts from the expander
`timescale 1ns/100ps
module iex_core_model (
  input  logic       sys_clk,
  input  logic       rst_b,
  input  logic       cpu_irq,
  input  logic       take_en,
  input  logic [3:0] slow,
  output logic       core_take
);
  logic [3:0] wait_reg;

  // take only when allowed
  // A request is held for slow cycles first, so both prompt and late takes occur
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_reg  <= 4'h0;
      core_take <= 1'b0;
    end else if (!cpu_irq || core_take || !take_en) begin
      wait_reg  <= 4'h0;
      core_take <= 1'b0;
    end else if (wait_reg == slow) begin
      core_take <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // iex_core_model

// file: verif/tb_peripheral_interrupt_expander.sv
// Self-checking testbench of the interrupt expander
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_peripheral_interrupt_expander;
  import iex_pkg::*;
  logic                   sys_clk       = 1'b0;
  logic                   rst_b         = 1'b0;
  logic [IEX_SOURCES-1:0] periph_irq    = '0;
  logic                   timer1_irq    = 1'b0;
  logic                   timer2_irq    = 1'b0;
  logic [IEX_ADDR_W-1:0]  avs_address   = '0;
  logic                   avs_read      = 1'b0;
  logic                   avs_write     = 1'b0;
  logic [IEX_DATA_W-1:0]  avs_writedata = '0;
  logic [IEX_DATA_W-1:0]  avs_readdata;
  logic                   avs_waitrequest;
  logic                   core_take;
  logic                   cpu_irq;
  iex_vec_s               vec_out;
  logic                   boot_fetch;
  logic [IEX_PC_W-1:0]    boot_addr;
  logic                   irq;
  logic                   take_en       = 1'b0;
  logic [3:0]             slow          = 4'h0;
  logic [31:0]            vram [IEX_VEC_DEPTH];
  logic [31:0]            rq [$];
  logic [39:0]            vq [$];
  logic [31:0]            er;
  logic [39:0]            ev;
  int                     n_fail        = 0;
  int                     n_tests       = 0;
  int                     b, lo, hi;

  always #12.5 sys_clk = ~sys_clk;

  iex_top u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .periph_irq(periph_irq),
    .timer1_irq(timer1_irq), .timer2_irq(timer2_irq), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_take(core_take),
    .cpu_irq(cpu_irq), .vec_out(vec_out), .boot_fetch(boot_fetch),
    .boot_addr(boot_addr), .irq(irq)
  );

  iex_core_model u_core (
    .sys_clk(sys_clk), .rst_b(rst_b), .cpu_irq(cpu_irq),
    .take_en(take_en), .slow(slow), .core_take(core_take)
  );

  // Result watcher: takes the oldest note whenever a result shows
  // Looked at mid-cycle, so the flops launched by the edge have settled
  always @(negedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      er = rq.pop_front();
      `CHK("readdata", er, avs_readdata)
    end
    if (vec_out.valid === 1'b1) begin
      ev = vq.pop_front();
      `CHK("vector", ev, {vec_out.index, vec_out.addr})
    end
  end

  task automatic close_out;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Request is held until the edge after waitrequest is seen low mid-cycle
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic wt;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    // Waitrequest is read mid-cycle, where it stands for the coming edge
    do begin
      @(negedge sys_clk);
      wt = avs_waitrequest;
      @(posedge sys_clk);
    end while (wt !== 1'b0);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, '0);
  endtask

  task automatic wait_vec(input int left);
    repeat (60) if (vq.size() > left) @(posedge sys_clk);
    `CHK("vector_wait", left, vq.size())
    #1;
  endtask

  task automatic pulse(input logic [IEX_SOURCES-1:0] m, input logic [1:0] t);
    @(posedge sys_clk);
    periph_irq <= m;
    {timer2_irq, timer1_irq} <= t;
    repeat (2) @(posedge sys_clk);
    periph_irq <= '0;
    {timer2_irq, timer1_irq} <= 2'b00;
  endtask

  function automatic logic [11:0] ga(input int g, input logic en);
    return 12'h100 + 12'(8 * g) + (en ? 12'h4 : 12'h0);
  endfunction

  function automatic logic [11:0] va(input int i);
    return 12'h400 + 12'(4 * i);
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial begin
    void'($urandom(67816));
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1;
    `CHK("boot_fetch", 1'b1, boot_fetch)
    `CHK("boot_addr", IEX_RESET_VECTOR, boot_addr)
    @(posedge sys_clk);
    #1;
    `CHK("boot_fetch", 1'b0, boot_fetch)
    rd(IEX_CTRL_OFS, 32'h2);
    rd(IEX_ACK_OFS, 32'h0);
    rd(IEX_CFLAG_OFS, 32'h0);
    rd(IEX_CEN_OFS, 32'h0);
    rd(IEX_EVT_OFS, 32'h0);
    for (int g = 0; g < IEX_GROUPS; g++) begin
      rd(ga(g, 1'b0), 32'h0);
      rd(ga(g, 1'b1), 32'h0);
    end
    wr(12'h01c, 32'hffffffff);
    rd(12'h01c, 32'h0);
    // one vector entry per source plus the two timer entries, loaded before enabling
    for (int i = 0; i < IEX_SOURCES + 2; i++) begin
      vram[i] = $urandom;
      wr(va(i), vram[i]);
    end
    rd(va(77), vram[77]);
    pulse('0, 2'b01);
    wr(IEX_CEN_OFS, 32'h1000);
    wr(IEX_CTRL_OFS, 32'h0);
    #1;
    `CHK("cpu_irq", 1'b1, cpu_irq)
    take_en <= 1'b1;
    repeat (8) @(posedge sys_clk);
    take_en <= 1'b0;
    rd(IEX_EVT_OFS, 32'h2);
    wr(IEX_EMASK_OFS, 32'h2);
    #1;
    `CHK("irq", 1'b1, irq)
    wr(IEX_EMASK_OFS, 32'h5);
    #1;
    `CHK("irq", 1'b0, irq)
    wr(IEX_EMASK_OFS, 32'h7);
    wr(IEX_EVT_OFS, 32'h2);
    #1;
    `CHK("irq", 1'b0, irq)
    vq.push_back({IEX_TIMER1_VEC, vram[192]});
    slow <= 4'($urandom % 16);
    take_en <= 1'b1;
    wr(IEX_CTRL_OFS, 32'h1);
    wait_vec(0);
    rd(IEX_CTRL_OFS, 32'h3);
    #1;
    `CHK("cpu_irq", 1'b0, cpu_irq)
    `CHK("irq", 1'b1, irq)
    wr(IEX_LASTVEC_OFS, 32'h0);
    rd(IEX_LASTVEC_OFS, {24'h0, IEX_TIMER1_VEC});
    wr(IEX_EVT_OFS, 32'h7);
    // core line enable gates the request
    pulse('0, 2'b10);
    wr(IEX_CTRL_OFS, 32'h1);
    #1;
    `CHK("cpu_irq", 1'b0, cpu_irq)
    rd(IEX_CFLAG_OFS, 32'h2000);
    vq.push_back({IEX_TIMER2_VEC, vram[193]});
    wr(IEX_CEN_OFS, 32'h3000);
    wait_vec(0);
    rd(IEX_CFLAG_OFS, 32'h0);
    // every group delivers its own source
    for (int g = 0; g < IEX_GROUPS; g++) begin
      b = $urandom % 16;
      slow <= 4'($urandom % 16);
      wr(ga(g, 1'b1), 32'h1 << b);
      wr(IEX_CEN_OFS, 32'h1 << g);
      pulse(192'h1 << (g * 16 + b), 2'b00);
      rd(ga(g, 1'b0), 32'h1 << b);
      rd(IEX_ACK_OFS, 32'h1 << g);
      vq.push_back({8'(g * 16 + b), vram[g * 16 + b]});
      wr(IEX_CTRL_OFS, 32'h1);
      wait_vec(0);
      rd(ga(g, 1'b0), 32'h0);
      wr(IEX_ACK_OFS, 32'h1 << g);
      rd(IEX_ACK_OFS, 32'h0);
    end
    // lower bit first, acknowledge holds the rest
    lo = $urandom % 8;
    hi = lo + 1 + $urandom % 7;
    wr(ga(3, 1'b1), (32'h1 << lo) | (32'h1 << hi));
    wr(IEX_CEN_OFS, 32'h8);
    pulse((192'h1 << (48 + lo)) | (192'h1 << (48 + hi)), 2'b00);
    vq.push_back({8'(48 + lo), vram[48 + lo]});
    wr(IEX_CTRL_OFS, 32'h1);
    wait_vec(0);
    wr(IEX_CTRL_OFS, 32'h1);
    #1;
    `CHK("cpu_irq", 1'b0, cpu_irq)
    rd(ga(3, 1'b0), 32'h1 << hi);
    vq.push_back({8'(48 + hi), vram[48 + hi]});
    wr(IEX_ACK_OFS, 32'h8);
    wait_vec(0);
    wr(ga(2, 1'b1), 32'h1);
    wr(ga(7, 1'b1), 32'h1);
    wr(IEX_ACK_OFS, 32'hfff);
    wr(IEX_CEN_OFS, 32'h84);
    vq.push_back({8'h20, vram[32]});
    vq.push_back({8'h70, vram[112]});
    pulse((192'h1 << 32) | (192'h1 << 112), 2'b00);
    rd(IEX_CFLAG_OFS, 32'h84);
    wr(IEX_CTRL_OFS, 32'h1);
    wait_vec(1);
    wr(IEX_CTRL_OFS, 32'h1);
    wait_vec(0);
    // flags cleared after forwarding: the take delivers nothing
    wr(IEX_ACK_OFS, 32'hfff);
    wr(IEX_CEN_OFS, 32'h4);
    wr(IEX_EVT_OFS, 32'h7);
    pulse(192'h1 << 32, 2'b00);
    rd(IEX_ACK_OFS, 32'h4);
    wr(ga(2, 1'b0), 32'h1);
    wr(IEX_CTRL_OFS, 32'h1);
    repeat (24) @(posedge sys_clk);
    rd(IEX_EVT_OFS, 32'h4);
    rd(IEX_CFLAG_OFS, 32'h0);
    repeat (4) @(posedge sys_clk);
    `CHK("reads_left", 0, rq.size())
    close_out();
  end
endmodule // tb_peripheral_interrupt_expander
